// ---- core/isa_io_recovery_decode_cfg_consts.vh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef ISA_IO_RECOVERY_DECODE_CFG_CONSTS_VH
`define ISA_IO_RECOVERY_DECODE_CFG_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_IO_RECOVERY   8'h51
`define IDX_ROM_CONTROL   8'h52
`define IDX_INTERNAL_LO   8'h53
`define IDX_INTERNAL_HI   8'h5a
`define IDX_DECODE_TWO    8'h5b

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_IO_RECOVERY   8'h00
`define RST_ROM_CONTROL   8'h04
`define RST_DECODE_TWO    8'h00
`define RST_INTERNAL      8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define REC8_MSB          7
`define REC8_LSB          4
`define REC16_MSB         3
`define REC16_LSB         0
`define DEC2_RSVD_BIT     6
`define DEC2_POS_BIT      5

// ----------------------------------------------------------------------
// Timing counts in clocks
// ----------------------------------------------------------------------
`define FIXED_IO_DELAY    5'h01
`define FIELD_BASE_DELAY  5'h01

`endif

// ---- core/isa_io_recovery_decode_cfg.v ----
// ISA I/O recovery timing and BIOS ROM decode configuration registers.
//
// Operation
// - Bits 7:4 of the recovery register set the gap after 8-bit I/O cycles.
// - Bits 3:0 of the recovery register set the gap after 16-bit I/O cycles.
// - Each programmed gap comes on top of a fixed one-clock delay.
// - A field of zero gives one clock and all ones give sixteen clocks.
// - Decode control two sits at index 5Bh and resets to 00h.
// - Bit 5 of decode control two picks positive (1) or subtractive (0).
// - ROM control sits at index 52h and resets to 04h.
`timescale 1ns/1ns
`include "isa_io_recovery_decode_cfg_consts.vh"

module isa_io_recovery_decode_cfg (
  input  wire        I_SYS_CLK,
  input  wire        I_SRST,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg         o_pready,
  output reg  [31:0] o_prdata,
  output reg         o_pslverr,
  input  wire        i_io_cmd_active,
  input  wire        i_io_cycle_16bit,
  output reg         o_io8_ready,
  output reg         o_io16_ready,
  input  wire        i_rom_hit,
  output reg         o_rom_claim_fast,
  output reg         o_rom_claim_subtractive,
  output reg  [7:0]  o_rom_control
);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  reg  [7:0]  io_recovery_q;
  reg  [7:0]  decode_two_q;
  reg  [7:0]  internal_q [0:7];
  reg  [31:0] rdata_d;
  reg         err_d;
  wire [7:0]  idx;
  wire        addr_ok;
  wire        setup;
  wire        wr_en;
  wire [2:0]  int_sel;
  integer     k;

  assign idx     = i_paddr[9:2];
  assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);
  assign setup   = i_psel & ~i_penable & ~o_pready;
  assign wr_en   = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
  assign int_sel = idx[2:0] - 3'h3;

  // Read data and error are formed in the setup cycle so the answer
  // can come straight from flip-flops with no wait state.
  always @* begin
    rdata_d = 32'h0;
    err_d   = 1'b0;
    if (!addr_ok) begin
      err_d = 1'b1;
    end else if (idx == `IDX_IO_RECOVERY) begin
      rdata_d = {24'h0, io_recovery_q};
    end else if (idx == `IDX_ROM_CONTROL) begin
      rdata_d = {24'h0, o_rom_control};
    end else if (idx == `IDX_DECODE_TWO) begin
      rdata_d = {24'h0, decode_two_q};
    end else if (idx >= `IDX_INTERNAL_LO && idx <= `IDX_INTERNAL_HI) begin
      rdata_d = {24'h0, internal_q[int_sel]};
    end else begin
      err_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------

  // Ready is never raised two cycles running, so a master that keeps
  // penable high one cycle too long cannot trigger a second write.
  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_prdata  <= setup ? rdata_d : 32'h0;
      o_pslverr <= setup & err_d;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------

  // A refused access raises the error flag, which also blocks its write.
  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      io_recovery_q <= `RST_IO_RECOVERY;
      o_rom_control <= `RST_ROM_CONTROL;
      decode_two_q  <= `RST_DECODE_TWO;
      for (k = 0; k < 8; k = k + 1) begin
        internal_q[k] <= `RST_INTERNAL;
      end
    end else if (wr_en) begin
      if (idx == `IDX_IO_RECOVERY) begin
        io_recovery_q <= i_pwdata[7:0];
      end
      if (idx == `IDX_ROM_CONTROL) begin
        o_rom_control <= i_pwdata[7:0];
      end
      if (idx == `IDX_DECODE_TWO) begin
        // The reserved bit is held at zero whatever software writes.
        decode_two_q <= i_pwdata[7:0] & ~(8'h01 << `DEC2_RSVD_BIT);
      end
      // Internal words are plain storage; software should leave them.
      if (idx >= `IDX_INTERNAL_LO && idx <= `IDX_INTERNAL_HI) begin
        internal_q[int_sel] <= i_pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // I/O recovery timers, one per cycle width
  // ----------------------------------------------------------------------
  reg        cmd_q;
  wire       cmd_end;
  wire [1:0] done;

  // The engine is trusted to wait for ready; a strobe that starts early
  // restarts nothing here and is only timed again when it ends.

  assign cmd_end = cmd_q & ~i_io_cmd_active;

  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      cmd_q <= 1'b0;
    end else begin
      cmd_q <= i_io_cmd_active;
    end
  end

  // ----------------------------------------------------------------------
  // Per-width counters
  // ----------------------------------------------------------------------

  genvar w;
  generate
    for (w = 0; w < 2; w = w + 1) begin : g_rec
      reg  [4:0] cnt_q;
      reg  [4:0] cnt_d;
      reg        width_q;
      wire [3:0] field;
      wire       mine;

      // Lane 0 times 8-bit cycles, lane 1 times 16-bit cycles.
      assign field = (w == 0) ?
        io_recovery_q[`REC8_MSB:`REC8_LSB] :
        io_recovery_q[`REC16_MSB:`REC16_LSB];
      assign mine  = (width_q == (w == 1));

      always @* begin
        cnt_d = cnt_q;
        if (cmd_end && mine) begin
          // Fixed controller delay plus field+1 programmed clocks.
          cnt_d = `FIXED_IO_DELAY + `FIELD_BASE_DELAY + {1'b0, field};
        end else if (cnt_q != 5'h00) begin
          cnt_d = cnt_q - 5'h01;
        end
      end

      always @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
          cnt_q   <= 5'h00;
          width_q <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          if (i_io_cmd_active) begin
            width_q <= i_io_cycle_16bit;
          end
        end
      end

      assign done[w] = (cnt_d == 5'h00) && !(cmd_end && mine);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Ready outputs
  // ----------------------------------------------------------------------

  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_io8_ready  <= 1'b1;
      o_io16_ready <= 1'b1;
    end else begin
      o_io8_ready  <= done[0];
      o_io16_ready <= done[1];
    end
  end

  // ----------------------------------------------------------------------
  // ROM decode claim
  // ----------------------------------------------------------------------
  wire pos_decode;

  assign pos_decode = decode_two_q[`DEC2_POS_BIT];

  // Both claims register one clock after the hit; bit 5 picks positive or subtractive.
  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_rom_claim_fast        <= 1'b0;
      o_rom_claim_subtractive <= 1'b0;
    end else begin
      o_rom_claim_fast        <= i_rom_hit & pos_decode;
      o_rom_claim_subtractive <= i_rom_hit & ~pos_decode;
    end
  end

endmodule

// ---- bench/isa_io_recovery_decode_cfg_asserts.sv ----
// Port checker for the recovery and decode configuration block.
`timescale 1ns/1ns
module isa_cfg_checker (
  input wire        I_SYS_CLK, I_SRST, i_psel, i_penable, o_pready,
  input wire        o_pslverr, i_io_cmd_active, o_io8_ready, o_io16_ready,
  input wire        i_rom_hit, o_rom_claim_fast, o_rom_claim_subtractive,
  input wire [31:0] o_prdata
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  property p_ans; i_psel && !i_penable && !o_pready |=> o_pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_pulse; o_pready |=> !o_pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_zero; !o_pready |-> o_prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("stray data");
  property p_hit;
    i_rom_hit |=> o_rom_claim_fast != o_rom_claim_subtractive;
  endproperty
  a_hit: assert property (p_hit) else $error("no claim");
  property p_idle;
    !i_rom_hit |=> !o_rom_claim_fast && !o_rom_claim_subtractive;
  endproperty
  a_idle: assert property (p_idle) else $error("stray claim");
  property p_drop; $fell(i_io_cmd_active) |=> !(o_io8_ready && o_io16_ready);
  endproperty
  a_drop: assert property (p_drop) else $error("no gap");
  property p_gap8; $fell(o_io8_ready) |-> ##[2:17] o_io8_ready; endproperty
  a_gap8: assert property (p_gap8) else $error("gap8 length");
  property p_gap16; $fell(o_io16_ready) |-> ##[2:17] o_io16_ready; endproperty
  a_gap16: assert property (p_gap16) else $error("gap16 length");
endmodule
bind isa_io_recovery_decode_cfg isa_cfg_checker i_isa_cfg_checker (.*);

// ---- bench/isa_engine_model.sv ----
// ISA cycle engine that issues I/O command strobes.
`timescale 1ns/1ns
module isa_engine_model (
  input  wire  I_SYS_CLK,
  input  wire  o_io8_ready,
  input  wire  o_io16_ready,
  output logic i_io_cmd_active = 1'b0,
  output logic i_io_cycle_16bit = 1'b0
);
  task io_cycle(logic w);
    @(posedge I_SYS_CLK);
    while ((w ? o_io16_ready : o_io8_ready) !== 1'b1) begin
      @(posedge I_SYS_CLK);
    end
    i_io_cmd_active <= 1'b1;
    i_io_cycle_16bit <= w;
    repeat (3) @(posedge I_SYS_CLK);
    i_io_cmd_active <= 1'b0;
    // The width line is flipped once idle so a stale value is not trusted.
    i_io_cycle_16bit <= !w;
  endtask
endmodule

// ---- bench/isa_io_recovery_decode_cfg_bench.sv ----
// Self-checking bench for the recovery and decode configuration block.
`timescale 1ns/1ns
module isa_io_recovery_decode_cfg_bench;
  logic I_SYS_CLK = 0, I_SRST = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic i_rom_hit = 0, o_pready, o_pslverr, i_io_cmd_active, er;
  logic i_io_cycle_16bit, o_io8_ready, o_io16_ready;
  logic o_rom_claim_fast, o_rom_claim_subtractive;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rd;
  logic [7:0]  o_rom_control;
  int err_count = 0, total_checks = 0, cyc = 0;
  typedef struct packed {logic [7:0] ix, d, x; logic e;} row_t;
  // Indices 53h to 5Ah are never written; bit 6 of 5Bh is written 0.
  row_t rows[4] = '{'{8'h51, 8'ha5, 8'ha5, 1'b0}, '{8'h52, 8'h5a, 8'h5a, 1'b0},
                    '{8'h5b, 8'hbf, 8'hbf, 1'b0}, '{8'h50, 8'h11, 8'h00, 1'b1}};
  isa_io_recovery_decode_cfg i_isa_io_recovery_decode_cfg (.*);
  isa_engine_model i_isa_engine_model (.*);
  initial forever #25 I_SYS_CLK = ~I_SYS_CLK;
  always @(posedge I_SYS_CLK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task chk(string s, logic [31:0] x, logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  task apb(logic w, logic [7:0] ix, logic [7:0] d);
    @(posedge I_SYS_CLK);
    i_psel <= 1; i_penable <= 0; i_pwrite <= w;
    i_paddr <= {2'b0, ix, 2'b0}; i_pwdata <= {24'h0, d};
    @(posedge I_SYS_CLK);
    i_penable <= 1;
    @(posedge I_SYS_CLK);
    while (o_pready !== 1'b1) begin
      @(posedge I_SYS_CLK);
    end
    rd = o_prdata; er = o_pslverr;
    i_psel <= 0; i_penable <= 0;
  endtask
  task rec(logic w, logic [3:0] f);
    int lo, oth;
    lo = 0; oth = 0;
    apb(1, 8'h51, w ? {~f, f} : {f, ~f});
    i_isa_engine_model.io_cycle(w);
    repeat (24) begin
      @(posedge I_SYS_CLK);
      lo += ((w ? o_io16_ready : o_io8_ready) !== 1'b1);
      oth += ((w ? o_io8_ready : o_io16_ready) !== 1'b1);
    end
    chk("gap", f + 2, lo);
    chk("other lane", 0, oth);
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge I_SYS_CLK);
    I_SRST <= 0;
    foreach (rows[i]) begin
      apb(1, rows[i].ix, rows[i].d);
      chk("write err", rows[i].e, er);
      apb(0, rows[i].ix, 8'h00);
      chk("read", rows[i].x, rd);
      chk("read err", rows[i].e, er);
    end
    chk("rom out", 8'h5a, o_rom_control);
    $display("register rows done");
    I_SRST <= 1;
    repeat (10) @(posedge I_SYS_CLK);
    I_SRST <= 0;
    chk("rom reset", 8'h04, o_rom_control);
    chk("ready reset", 2'b11, {o_io8_ready, o_io16_ready});
    apb(0, 8'h5b, 8'h00);
    chk("dec2 reset", 8'h00, rd);
    apb(0, 8'h52, 8'h00);
    chk("rom reset rd", 8'h04, rd);
    $display("reset test done");
    for (int k = 0; k < 4; k++) rec(k[0], k[1] ? 4'hf : 4'h0);
    $display("recovery test done");
    for (int k = 0; k < 2; k++) begin
      apb(1, 8'h5b, k ? 8'h20 : 8'h00);
      i_rom_hit <= 1;
      repeat (2) @(posedge I_SYS_CLK);
      chk("claim", {k[0], !k[0]}, {o_rom_claim_fast, o_rom_claim_subtractive});
      i_rom_hit <= 0;
    end
    $display("claim test done");
    tally_and_finish();
  end
endmodule
